// >>> logic/oct_pkg.sv
// Purpose: Shared constants and types for the opcode decoder and state timing.
// Assumes: One 200 MHz clock; instruction words arrive already fetched.
// Notes: Constants are shared by the decoder, the summer and the checks.
// Overview of operation
// - Class comes from first byte, bits 15:8.
// - Bit 7 splits pairs sharing first byte.
// - Row 7 upper half: move, block move, bits.
// - Low bits separate slow-peripheral moves from moves.
// - Push and pop decode as plain moves.
// - Branch aliases decode as their base branches.
// - Total is sum of count times cost.
// - External byte 3+m, word or vector 6+2m.
// - Slow peripheral byte access takes 9..16 states.
// - Mode 1 sends instruction fetches external.
// - Absolute bit set: two fetches, two bytes.
package oct_pkg;
    localparam int CNT_W = 4;
    localparam int WAIT_W = 4;
    localparam int COST_W = 6;
    localparam int TOT_W = 10;
    localparam int NUM_TYPES = 6;

    // Cycle type indices.
    localparam int CT_FETCH = 0;
    localparam int CT_BRADDR = 1;
    localparam int CT_STACK = 2;
    localparam int CT_BYTE = 3;
    localparam int CT_WORD = 4;
    localparam int CT_INTERNAL = 5;

    // Map rows and columns.
    localparam logic [3:0] ROW_BRANCH = 4'h4;
    localparam logic [3:0] ROW_CALL = 4'h5;
    localparam logic [3:0] ROW_BIT_REG = 4'h6;
    localparam logic [3:0] ROW_SEVEN = 4'h7;
    localparam logic [3:0] ROW_MOV_IMM = 4'h2;
    localparam logic [3:0] ROW_MOV_ABS = 4'h3;
    localparam logic [3:0] ROW_MOV_DISP = 4'hF;
    localparam logic [3:0] COL_BIT_SET = 4'h0;
    localparam logic [3:0] COL_MOV_LO = 4'h8;
    localparam logic [3:0] COL_MOV_HI = 4'hA;
    localparam logic [3:0] COL_BLOCK_MOVE = 4'hB;
    localparam logic [3:0] COL_BITS_AT_REG = 4'hD;
    localparam logic [3:0] COL_BITS_ABS = 4'hF;
    localparam logic [3:0] COL_CALL_LO = 4'hD;
    localparam logic [3:0] COL_CALL_IND = 4'hF;
    localparam logic [3:0] COL_BR_ALWAYS = 4'h0;
    localparam logic [3:0] COL_BR_NEVER = 4'h1;
    localparam logic [3:0] COL_BR_CC = 4'h4;
    localparam logic [3:0] COL_BR_CS = 4'h5;
    localparam logic [7:0] SLOW_FIRST_BYTE = 8'h6A;
    localparam logic [2:0] SLOW_SEL = 3'h4;
    localparam logic [7:0] OP2_BIT_SET_IMM = 8'h70;
    localparam logic [7:0] OP2_BIT_SET_REG = 8'h60;
    localparam int BIT7 = 7;

    // State costs.
    localparam logic [COST_W-1:0] S_ONCHIP = 6'h02;
    localparam logic [COST_W-1:0] S_REG_BYTE = 6'h03;
    localparam logic [COST_W-1:0] S_REG_WORD = 6'h06;
    localparam logic [COST_W-1:0] S_SLOW_MIN = 6'h09;
    localparam int SLOW_PHASES = 8;

    typedef enum logic [1:0] {OCT_LOC_ONCHIP, OCT_LOC_REGFIELD, OCT_LOC_EXTERNAL,
                              OCT_LOC_RSVD} oct_loc_t;

    typedef enum logic [3:0] {
        OCT_OTHER, OCT_MOVE, OCT_BLOCK_MEMORY_MOVE, OCT_MOVE_FROM_SLOW_PERIPHERAL,
        OCT_MOVE_TO_SLOW_PERIPHERAL, OCT_BRANCH_ALWAYS, OCT_BRANCH_NEVER,
        OCT_BRANCH_CARRY_CLEAR, OCT_BRANCH_CARRY_SET, OCT_BRANCH_COND,
        OCT_BIT_SET_OP, OCT_BIT_MANIP, OCT_SUBROUTINE_CALL
    } oct_class_t;

    typedef logic [NUM_TYPES-1:0][CNT_W-1:0] oct_counts_t;
    typedef logic [NUM_TYPES-1:0][COST_W-1:0] oct_costs_t;
endpackage

// >>> logic/oct_cycle_if.sv
// Purpose: Carries cycle counts and per-type costs from decoder to summer.
// Assumes: Both ends on the same clock.
// Notes: One valid qualifies counts and costs together.
`timescale 1ns/1ps
interface oct_cycle_if;
    import oct_pkg::*;
    logic valid;
    oct_counts_t counts;
    oct_costs_t costs;
    modport dec (output valid, output counts, output costs);
    modport sum (input valid, input counts, input costs);
endinterface

// >>> logic/oct_state_sum.sv
// Purpose: Weighted sum of cycle counts into execution states.
// Assumes: Counts and costs stable while valid is high.
// Notes: Registered result one cycle after valid.
`timescale 1ns/1ps
module oct_state_sum (
    input wire logic clk_in,
    input wire logic rst_in,
    oct_cycle_if.sum cyc,
    output logic [oct_pkg::TOT_W-1:0] total_out,
    output logic valid_out
);
    import oct_pkg::*;

    function automatic logic [TOT_W-1:0] weigh(input oct_counts_t c, input oct_costs_t s);
        logic [TOT_W-1:0] acc;
        acc = '0;
        for (int i = 0; i < NUM_TYPES; i++) begin
            acc = TOT_W'(acc + TOT_W'(c[i]) * TOT_W'(s[i]));
        end
        return acc;
    endfunction

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            total_out <= '0;
        end else if (cyc.valid) begin
            total_out <= weigh(cyc.counts, cyc.costs);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_out <= 1'b0;
        end else begin
            valid_out <= cyc.valid;
        end
    end
endmodule

// >>> logic/oct_decoder.sv
// Purpose: First-byte opcode decode and execution state count.
// Assumes: word1/word2 valid on insn_valid_in; mode pin is asynchronous.
// Notes: Decode registers in one cycle, the state total one cycle later.
`timescale 1ns/1ps
module oct_decoder #(
    parameter int WAIT_MAX = 15
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic insn_valid_in,
    input wire logic [15:0] insn_word1_in,
    input wire logic [15:0] insn_word2_in,
    input wire logic mode1_in,
    input wire logic [oct_pkg::WAIT_W-1:0] wait_states_in,
    input wire oct_pkg::oct_loc_t data_loc_in,
    input wire oct_pkg::oct_loc_t stack_loc_in,
    output oct_pkg::oct_class_t class_out,
    output logic [3:0] branch_cond_out,
    output logic fetch_external_out,
    output oct_pkg::oct_counts_t counts_out,
    output logic [oct_pkg::TOT_W-1:0] total_states_out,
    output logic total_valid_out
);
    import oct_pkg::*;

    localparam int PH_W = $clog2(SLOW_PHASES);

    // Checks run at elaboration, so a bad parameter never reaches a netlist.
    if (WAIT_MAX < 0 || WAIT_MAX > (1 << WAIT_W) - 1) begin : g_wait_range
        $error("WAIT_MAX does not fit the wait-state field.");
    end

    // The worst external word cost, six plus two per wait state, must fit.
    if (int'(S_REG_WORD) + 2 * WAIT_MAX > (1 << COST_W) - 1) begin : g_cost_range
        $error("WAIT_MAX makes external costs overflow the cost field.");
    end

    // The phase counter wraps, so the window only works for a power of two.
    if (SLOW_PHASES != (1 << PH_W) || PH_W == 0) begin : g_phase_count
        $error("SLOW_PHASES must be a power of two above one.");
    end

    oct_cycle_if cyc ();

    logic mode_meta;
    logic mode_sync;
    logic [PH_W-1:0] slow_phase;
    oct_class_t next_class;
    oct_counts_t next_counts;
    oct_costs_t next_costs;
    logic slow_access;
    logic [COST_W-1:0] slow_cost;

    // The mode strap is a pin; two flops before any use.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_meta <= 1'b0;
            mode_sync <= 1'b0;
        end else begin
            mode_meta <= mode1_in;
            mode_sync <= mode_meta;
        end
    end

    // Slow peripheral clock phase; an access waits for its next edge.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            slow_phase <= '0;
        end else begin
            slow_phase <= PH_W'(slow_phase + 1'b1);
        end
    end

    function automatic logic [COST_W-1:0] cost(input oct_loc_t loc,
                                                input logic [COST_W-1:0] reg_cost,
                                                input logic wide,
                                                input logic [WAIT_W-1:0] m);
        logic [COST_W-1:0] r;
        r = S_ONCHIP;
        unique case (loc)
            OCT_LOC_ONCHIP: r = S_ONCHIP;
            OCT_LOC_REGFIELD: r = reg_cost;
            OCT_LOC_EXTERNAL, OCT_LOC_RSVD: begin
                r = wide ? COST_W'(S_REG_WORD + 2 * m) : COST_W'(S_REG_BYTE + m);
            end
        endcase
        return r;
    endfunction

    function automatic logic [CNT_W-1:0] n(input int v);
        return CNT_W'(v);
    endfunction

    always_comb begin
        logic [3:0] row;
        logic [3:0] col;
        logic [7:0] op2;
        row = insn_word1_in[15:12];
        col = insn_word1_in[11:8];
        op2 = insn_word2_in[15:8];
        next_class = OCT_OTHER;
        next_counts = '0;
        next_counts[CT_FETCH] = n(1);
        slow_access = 1'b0;
        if (insn_word1_in[15:8] == SLOW_FIRST_BYTE
                && insn_word1_in[6:4] == SLOW_SEL) begin
            slow_access = 1'b1;
            next_class = insn_word1_in[BIT7] ? OCT_MOVE_TO_SLOW_PERIPHERAL
                                             : OCT_MOVE_FROM_SLOW_PERIPHERAL;
            next_counts[CT_FETCH] = n(2);
            next_counts[CT_BYTE] = n(1);
        end else if (row == ROW_BRANCH) begin
            next_counts[CT_FETCH] = n(2);
            unique case (col)
                COL_BR_ALWAYS: next_class = OCT_BRANCH_ALWAYS;
                COL_BR_NEVER: next_class = OCT_BRANCH_NEVER;
                COL_BR_CC: next_class = OCT_BRANCH_CARRY_CLEAR;
                COL_BR_CS: next_class = OCT_BRANCH_CARRY_SET;
                default: next_class = OCT_BRANCH_COND;
            endcase
        end else if (row == ROW_CALL && col >= COL_CALL_LO) begin
            next_class = OCT_SUBROUTINE_CALL;
            next_counts[CT_FETCH] = n(2);
            next_counts[CT_STACK] = n(1);
            if (col == COL_CALL_IND) begin
                next_counts[CT_BRADDR] = n(1);
            end
        end else if (row == ROW_BIT_REG && col == COL_BIT_SET) begin
            next_class = OCT_BIT_SET_OP;
        end else if (row == ROW_SEVEN && col >= COL_MOV_LO) begin
            if (col <= COL_MOV_HI) begin
                next_class = OCT_MOVE;
            end else if (col == COL_BLOCK_MOVE) begin
                next_class = OCT_BLOCK_MEMORY_MOVE;
                next_counts[CT_FETCH] = n(2);
            end else begin
                next_counts[CT_FETCH] = n(2);
                next_counts[CT_BYTE] = n(1);
                if ((col == COL_BITS_ABS || col == COL_BITS_AT_REG)
                        && (op2 == OP2_BIT_SET_IMM || op2 == OP2_BIT_SET_REG)) begin
                    next_class = OCT_BIT_SET_OP;
                    next_counts[CT_BYTE] = n(2);
                end else begin
                    next_class = OCT_BIT_MANIP;
                end
            end
        end else if (row == ROW_MOV_IMM || row == ROW_MOV_ABS || row == ROW_MOV_DISP
                || (row == ROW_BIT_REG && col >= COL_MOV_LO)) begin
            next_class = OCT_MOVE;
        end
    end

    // Class and column hold until the next taken word, so a slow consumer
    // may look at them at any time between instructions.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            class_out <= OCT_OTHER;
            branch_cond_out <= '0;
        end else if (insn_valid_in) begin
            class_out <= next_class;
            branch_cond_out <= insn_word1_in[11:8];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            counts_out <= '0;
        end else if (insn_valid_in) begin
            counts_out <= next_counts;
        end
    end

    // The summer has its own copy, so the output port drives nothing inside.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cyc.counts <= '0;
        end else if (insn_valid_in) begin
            cyc.counts <= next_counts;
        end
    end

    // The slow cost is fixed by the phase at the taken edge; a real access
    // would be measured as it runs, which this block does not model.
    always_comb begin
        slow_cost = COST_W'(S_SLOW_MIN + COST_W'(slow_phase));
    end

    // Costs depend on the locations and wait states given with this instruction, the synchronised mode strap and the slow phase.
    always_comb begin
        next_costs = '0;
        next_costs[CT_FETCH] = cost(mode_sync ? OCT_LOC_EXTERNAL : OCT_LOC_ONCHIP,
                                    S_ONCHIP, 1'b1, wait_states_in);
        next_costs[CT_BRADDR] = cost(data_loc_in, S_REG_WORD, 1'b1, wait_states_in);
        next_costs[CT_STACK] = cost(stack_loc_in, S_REG_WORD, 1'b1, wait_states_in);
        if (slow_access) begin
            next_costs[CT_BYTE] = slow_cost;
        end else begin
            next_costs[CT_BYTE] = cost(data_loc_in, S_REG_BYTE, 1'b0, wait_states_in);
        end
        next_costs[CT_WORD] = cost(data_loc_in, S_REG_WORD, 1'b1, wait_states_in);
        next_costs[CT_INTERNAL] = S_ONCHIP;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cyc.costs <= '0;
        end else if (insn_valid_in) begin
            cyc.costs <= next_costs;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cyc.valid <= 1'b0;
        end else begin
            cyc.valid <= insn_valid_in;
        end
    end

    // The flag lags the synchronised strap by one cycle, as every output is a flop.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fetch_external_out <= 1'b0;
        end else begin
            fetch_external_out <= mode_sync;
        end
    end

    oct_state_sum u_sum (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .cyc(cyc),
        .total_out(total_states_out),
        .valid_out(total_valid_out)
    );
endmodule

// >>> dv/oct_dec_monitor.sv
// Purpose: Port checks for the opcode decoder.
// Assumes: One clock, reset active high.
// Notes: Bound to every decoder instance.
`timescale 1ns/1ps
module oct_dec_monitor #(
    parameter int WAIT_MAX = 15
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic insn_valid_in,
    input wire logic [15:0] insn_word1_in,
    input wire logic [15:0] insn_word2_in,
    input wire logic mode1_in,
    input wire oct_pkg::oct_class_t class_out,
    input wire logic [3:0] branch_cond_out,
    input wire logic fetch_external_out,
    input wire oct_pkg::oct_counts_t counts_out,
    input wire logic total_valid_out
);
    import oct_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_total_two_late: assert property (insn_valid_in |=> ##1 total_valid_out)
        else $error("total valid late");
    a_cond_low_nibble: assert property (insn_valid_in |=>
        branch_cond_out == $past(insn_word1_in[11:8])) else $error("column wrong");
    a_alias_always: assert property (insn_valid_in && insn_word1_in[15:8] == 8'h40
        |=> class_out == OCT_BRANCH_ALWAYS) else $error("alias wrong");
    a_slow_pair_split: assert property (insn_valid_in && insn_word1_in[15:8] == 8'h6A
        && insn_word1_in[6:4] == 3'h4 |=> class_out == ($past(insn_word1_in[7])
        ? OCT_MOVE_TO_SLOW_PERIPHERAL : OCT_MOVE_FROM_SLOW_PERIPHERAL)) else $error("slow pair");
    a_push_is_move: assert property (insn_valid_in && insn_word1_in[15:8] == 8'h6D
        |=> class_out == OCT_MOVE) else $error("push not move");
    a_block_move_code: assert property (insn_valid_in && insn_word1_in[15:8] == 8'h7B
        |=> class_out == OCT_BLOCK_MEMORY_MOVE) else $error("block move");
    a_bit_set_abs: assert property (insn_valid_in && insn_word1_in[15:8] == 8'h7F
        && insn_word2_in[15:8] == 8'h70 |=> counts_out == 24'h002002) else $error("bit set");
    a_call_indirect: assert property (insn_valid_in && insn_word1_in[15:8] == 8'h5F
        |=> counts_out == 24'h000112) else $error("call counts");
    a_fetch_mode_pin: assert property ($stable(mode1_in) [*5] |->
        fetch_external_out == mode1_in) else $error("fetch location");
    a_class_holds: assert property (!insn_valid_in |=> $stable(class_out))
        else $error("class moved");
    c_slow_to: cover property (class_out == OCT_MOVE_TO_SLOW_PERIPHERAL);
    c_ext_total: cover property (total_valid_out && fetch_external_out);
    c_back_to_back: cover property (insn_valid_in [*2]);
endmodule

bind oct_decoder oct_dec_monitor #(.WAIT_MAX(WAIT_MAX)) u_mon (.clk_in(clk_in),
    .rst_in(rst_in), .insn_valid_in(insn_valid_in), .insn_word1_in(insn_word1_in),
    .insn_word2_in(insn_word2_in), .mode1_in(mode1_in), .class_out(class_out),
    .branch_cond_out(branch_cond_out), .fetch_external_out(fetch_external_out),
    .counts_out(counts_out), .total_valid_out(total_valid_out));

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the opcode decoder.
// Assumes: Inputs change on the falling edge.
// Notes: Slow peripheral phase is free running, so only its range is checked.
`timescale 1ns/1ps
module testbench;
    import oct_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic vld = 1'b0;
    logic [15:0] w1 = 16'h0000;
    logic [15:0] w2 = 16'h0000;
    logic mode1 = 1'b0;
    logic [3:0] m = 4'h0;
    oct_loc_t dloc = OCT_LOC_ONCHIP;
    oct_loc_t sloc = OCT_LOC_ONCHIP;
    oct_class_t cls;
    logic [3:0] cond;
    logic fext;
    oct_counts_t cnt;
    logic [9:0] tot;
    logic tval;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    oct_decoder uut (.clk_in(clk_in), .rst_in(rst_in), .insn_valid_in(vld),
        .insn_word1_in(w1), .insn_word2_in(w2), .mode1_in(mode1), .wait_states_in(m),
        .data_loc_in(dloc), .stack_loc_in(sloc), .class_out(cls), .branch_cond_out(cond),
        .fetch_external_out(fext), .counts_out(cnt), .total_states_out(tot),
        .total_valid_out(tval));

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic cmp_num(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic cmp_cls(input string what, input oct_class_t exp, input oct_class_t got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic finish_test;
        if (miscompares == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // A zero expected total means the slow peripheral window of 13 to 20 states.
    task automatic run(input logic [15:0] a, input logic [15:0] b, input oct_class_t ec,
                       input logic [9:0] et);
        @(negedge clk_in);
        vld = 1'b1;
        w1 = a;
        w2 = b;
        @(negedge clk_in);
        vld = 1'b0;
        cmp_cls("class", ec, cls);
        cmp_num("column", {20'h0, a[11:8]}, {20'h0, cond});
        @(negedge clk_in);
        cmp_num("total valid", 24'h1, {23'h0, tval});
        if (et != 10'h000) cmp_num("total", {14'h0, et}, {14'h0, tot});
        else cmp_num("slow total", 24'h1, {23'h0, tot >= 10'h00D && tot <= 10'h014});
        @(negedge clk_in);
        cmp_num("valid pulse", 24'h0, {23'h0, tval});
    endtask

    task automatic t_branches;
        run(16'h4010, 16'h0000, OCT_BRANCH_ALWAYS, 10'h004);
        run(16'h4110, 16'h0000, OCT_BRANCH_NEVER, 10'h004);
        run(16'h4410, 16'h0000, OCT_BRANCH_CARRY_CLEAR, 10'h004);
        run(16'h4510, 16'h0000, OCT_BRANCH_CARRY_SET, 10'h004);
        run(16'h4210, 16'h0000, OCT_BRANCH_COND, 10'h004);
    endtask

    task automatic t_rows;
        run(16'h7800, 16'h0000, OCT_MOVE, 10'h002);
        run(16'h7B5C, 16'h598F, OCT_BLOCK_MEMORY_MOVE, 10'h004);
        run(16'h7C00, 16'h7300, OCT_BIT_MANIP, 10'h006);
        run(16'h6010, 16'h0000, OCT_BIT_SET_OP, 10'h002);
        run(16'h6D70, 16'h0000, OCT_MOVE, 10'h002);
        run(16'h6A40, 16'h1234, OCT_MOVE_FROM_SLOW_PERIPHERAL, 10'h000);
        run(16'h6AC0, 16'h1234, OCT_MOVE_TO_SLOW_PERIPHERAL, 10'h000);
        run(16'h6A08, 16'h1234, OCT_MOVE, 10'h002);
    endtask

    task automatic t_external;
        mode1 = 1'b1;
        m = 4'h1;
        sloc = OCT_LOC_EXTERNAL;
        dloc = OCT_LOC_REGFIELD;
        repeat (5) @(negedge clk_in);
        cmp_num("fetch external", 24'h1, {23'h0, fext});
        run(16'h7FC7, 16'h7000, OCT_BIT_SET_OP, 10'h016);
        dloc = OCT_LOC_EXTERNAL;
        run(16'h5F30, 16'h0000, OCT_SUBROUTINE_CALL, 10'h020);
        cmp_num("call counts", 24'h000112, cnt);
        m = 4'h3;
        run(16'h7FC7, 16'h7000, OCT_BIT_SET_OP, 10'h024);
    endtask

    task automatic t_back_to_back;
        mode1 = 1'b0;
        repeat (5) @(negedge clk_in);
        vld = 1'b1;
        w1 = 16'h4010;
        @(negedge clk_in);
        w1 = 16'h7800;
        @(negedge clk_in);
        vld = 1'b0;
        cmp_cls("second class", OCT_MOVE, cls);
        cmp_num("first total", 24'h000004, {14'h0, tot});
        @(negedge clk_in);
        cmp_num("second total", 24'h000002, {14'h0, tot});
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        t_branches();
        t_rows();
        t_external();
        t_back_to_back();
        finish_test();
    end
endmodule
